//--- design/ram_mapped_flag_register_area.v
// Summary of operation
// - interrupt control words 0-3 reached only by bit set, clear, test
// - ordinary reads and writes leave control and flag words unchanged
// - bit set/clear also act on the display control register
// - flag words 0x20-0x21 hold system flags, 0x22-0x23 interrupt flags, same bit-only access
// - sixteen memory register digits for load and exchange instructions
// - thirty-two display digits drive segments, one lights a segment
// - 464 data digits banked by bank register; upper region unbanked
// - calls and interrupts push pc, status and carry, sixteen levels
// - both returns restore pc; only interrupt return restores flags
// - unused stack digits act as ordinary data storage
// - bit set ignored on request, capture and ram enable flags
// - stack clear bit ignores set; unused bits ignore set and clear
// - watchdog flag set only; cleared by reset or stop cancel
// - direct transfer flag held clear in active mode, set in subactive
// - test of inhibited or missing bit gives undefined status
// - enable, masks, low speed, current off accept all bit operations
// - each interrupt source has its own request flag and mask bit
`timescale 1ns/100ps
`default_nettype none
`include "ram_map_regs.vh"
module ram_mapped_flag_register_area
#(
    parameter AW = 10,
    parameter DW = 4
)
(
    input  wire          mclk_i,
    input  wire          rst_i,
    input  wire [AW-1:0] addr_i,
    input  wire [DW-1:0] wdata_i,
    input  wire          rd_i,
    input  wire          wr_i,
    input  wire          bit_set_instr_i,
    input  wire          bit_clear_instr_i,
    input  wire          bit_test_instr_i,
    input  wire [1:0]    bit_sel_i,
    input  wire          subactive_i,
    input  wire          stop_cancel_input_i,
    input  wire [9:0]    irq_req_i,
    input  wire          capture_status_set_i,
    input  wire          capture_error_set_i,
    input  wire          ram_enabled_set_i,
    input  wire          conversion_done_i,
    input  wire          call_push_i,
    input  wire          irq_push_i,
    input  wire          subroutine_return_i,
    input  wire          interrupt_return_i,
    input  wire [13:0]   pc_i,
    input  wire          status_flag_i,
    input  wire          carry_flag_i,
    output reg  [DW-1:0] rdata_o,
    output reg           bit_test_o,
    output reg  [13:0]   pc_o,
    output reg           restore_flags_o,
    output reg           status_flag_o,
    output reg           carry_flag_o,
    output reg           restore_valid_o,
    output reg  [31:0]   segment_o,
    output reg  [DW-1:0] display_control_reg_o,
    output reg  [31:0]   flag_words_o,
    output reg           stack_ptr_clear_o
);

    // flag words: 0..3 interrupt control, 4..7 register flags
    reg [DW-1:0] flg_reg [0:7];
    reg [DW-1:0] mem_reg [0:1023];
    reg [DW-1:0] bank_hi_reg [0:463];
    reg [DW-1:0] dcr_reg;
    reg [3:0]    sp_reg;
    reg [DW-1:0] flg_next [0:7];
    integer      i;

    // which flag word (0..7) an address selects, 8 when none
    function [3:0] flag_idx;
        input [AW-1:0] a;
        begin
            if (a <= `ICW3_ADDR)
                flag_idx = {2'b00, a[1:0]};
            else if (a >= `SFW0_ADDR && a <= `SIFW_ADDR)
                flag_idx = {2'b01, a[1:0]};
            else
                flag_idx = 4'h8;
        end
    endfunction

    // set permission per word and bit
    function set_ok;
        input [3:0] w;
        input [1:0] b;
        begin
            case (w)
                4'h0: set_ok = (b == 2'd0) || (b == 2'd3);
                4'h1, 4'h2, 4'h3, 4'h6: set_ok = b[0];
                4'h4: set_ok = (b != 2'd3) || subactive_i;
                4'h5: set_ok = (b == 2'd2);
                4'h7: set_ok = (b == 2'd3);
                default: set_ok = 1'b0;
            endcase
        end
    endfunction

    // clear permission per word and bit
    function clr_ok;
        input [3:0] w;
        input [1:0] b;
        begin
            case (w)
                4'h4: clr_ok = (b != 2'd1) && (b != 2'd2);
                4'h7: clr_ok = b[1];
                4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6: clr_ok = 1'b1;
                default: clr_ok = 1'b0;
            endcase
        end
    endfunction

    // banked data area lies in 0x090..0x25f
    function in_bank;
        input [AW-1:0] a;
        begin
            in_bank = (a >= `DATA_BASE) && (a <= `BANK_LAST);
        end
    endfunction

    wire [3:0] fidx = flag_idx(addr_i);
    wire       bank = mem_reg[`BANK_ADDR][0];
    wire [AW-1:0] boff = addr_i - `DATA_BASE;
    wire [AW-1:0] slot = `STACK_BASE + {4'h0, sp_reg, 2'b00};
    wire [AW-1:0] pslot = `STACK_BASE + {4'h0, sp_reg - 4'h1, 2'b00};

    // next flag state: hardware sets win over software clears
    always @*
    begin
        for (i = 0; i < 8; i = i + 1)
            flg_next[i] = flg_reg[i];
        if (fidx != 4'h8 && bit_set_instr_i && set_ok(fidx, bit_sel_i))
            flg_next[fidx[2:0]][bit_sel_i] = 1'b1;
        if (fidx != 4'h8 && bit_clear_instr_i && clr_ok(fidx, bit_sel_i))
            flg_next[fidx[2:0]][bit_sel_i] = 1'b0;
        if (!subactive_i)
            flg_next[4][`B_DIRECT_TRANSFER_FLAG] = 1'b0;
        if (stop_cancel_input_i)
            flg_next[4][`B_WATCHDOG_ACTIVE_FLAG] = 1'b0;
        if (conversion_done_i)
            flg_next[4][`B_CONVERSION_START_FLAG] = 1'b0;
        // request flags: bit 0 and 2 of words 1..3 and 6, bit 2 of words 0 and 7
        if (irq_req_i[0]) flg_next[0][2] = 1'b1;
        if (irq_req_i[1]) flg_next[1][0] = 1'b1;
        if (irq_req_i[2]) flg_next[1][2] = 1'b1;
        if (irq_req_i[3]) flg_next[2][0] = 1'b1;
        if (irq_req_i[4]) flg_next[2][2] = 1'b1;
        if (irq_req_i[5]) flg_next[3][0] = 1'b1;
        if (irq_req_i[6]) flg_next[3][2] = 1'b1;
        if (irq_req_i[7]) flg_next[6][0] = 1'b1;
        if (irq_req_i[8]) flg_next[6][2] = 1'b1;
        if (irq_req_i[9]) flg_next[7][2] = 1'b1;
        if (capture_status_set_i) flg_next[5][`B_CAPTURE_STATUS_FLAG] = 1'b1;
        if (capture_error_set_i)  flg_next[5][`B_CAPTURE_ERROR_FLAG] = 1'b1;
        if (ram_enabled_set_i)    flg_next[5][`B_RAM_ENABLED_FLAG] = 1'b1;
        flg_next[0][`B_RSP] = 1'b0;                // clear pulse only
    end

    // flag words and display control register
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (i = 0; i < 8; i = i + 1)
                flg_reg[i] <= `FLAG_RST;
            dcr_reg <= `DCR_RST;
            stack_ptr_clear_o <= 1'b0;
            flag_words_o <= 32'h0000_0000;
            display_control_reg_o <= `DCR_RST;
        end
        else
        begin
            for (i = 0; i < 8; i = i + 1)
                flg_reg[i] <= flg_next[i];
            stack_ptr_clear_o <= (fidx == 4'h0) && bit_clear_instr_i
                                 && (bit_sel_i == 2'd1);
            // output copy moves with the register so it never lags a cycle
            if (addr_i == `DCR_ADDR && wr_i)
            begin
                dcr_reg <= wdata_i;
                display_control_reg_o <= wdata_i;
            end
            else if (addr_i == `DCR_ADDR && bit_set_instr_i)
            begin
                dcr_reg[bit_sel_i] <= 1'b1;
                display_control_reg_o[bit_sel_i] <= 1'b1;
            end
            else if (addr_i == `DCR_ADDR && bit_clear_instr_i)
            begin
                dcr_reg[bit_sel_i] <= 1'b0;
                display_control_reg_o[bit_sel_i] <= 1'b0;
            end
            flag_words_o <= {flg_next[7], flg_next[6], flg_next[5],
                             flg_next[4], flg_next[3], flg_next[2],
                             flg_next[1], flg_next[0]};
        end
    end

    // digit storage; no reset, contents undefined until written
    always @(posedge mclk_i)
    begin
        if (call_push_i || irq_push_i)
        begin
            mem_reg[slot]        <= pc_i[3:0];
            mem_reg[slot + 10'd1] <= pc_i[7:4];
            mem_reg[slot + 10'd2] <= pc_i[11:8];
            mem_reg[slot + 10'd3] <= {status_flag_i, carry_flag_i,
                                     pc_i[13:12]};
        end
        else if (wr_i && fidx == 4'h8 && addr_i != `DCR_ADDR)
        begin
            // flag words never take ordinary writes
            if (in_bank(addr_i) && bank)
                bank_hi_reg[boff[8:0]] <= wdata_i;
            else
                mem_reg[addr_i] <= wdata_i;
        end
    end

    // stack pointer and return data
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sp_reg <= 4'h0;
            pc_o <= 14'h0000;
            status_flag_o <= 1'b0;
            carry_flag_o <= 1'b0;
            restore_flags_o <= 1'b0;
            restore_valid_o <= 1'b0;
        end
        else
        begin
            restore_valid_o <= subroutine_return_i || interrupt_return_i;
            restore_flags_o <= interrupt_return_i;
            if (stack_ptr_clear_o)
                sp_reg <= 4'h0;
            else if (call_push_i || irq_push_i)
                sp_reg <= sp_reg + 4'h1;
            else if (subroutine_return_i || interrupt_return_i)
            begin
                sp_reg <= sp_reg - 4'h1;
                pc_o <= {mem_reg[pslot + 10'd3][1:0],
                         mem_reg[pslot + 10'd2],
                         mem_reg[pslot + 10'd1], mem_reg[pslot]};
                if (interrupt_return_i)
                begin
                    status_flag_o <= mem_reg[pslot + 10'd3][3];
                    carry_flag_o <= mem_reg[pslot + 10'd3][2];
                end
            end
        end
    end

    // reads: flag words read zero through ordinary reads
    always @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o <= 4'h0;
            bit_test_o <= 1'b0;
            segment_o <= 32'h0000_0000;
        end
        else
        begin
            if (rd_i && fidx != 4'h8)
                rdata_o <= 4'h0;
            else if (rd_i && addr_i == `DCR_ADDR)
                rdata_o <= dcr_reg;
            else if (rd_i && in_bank(addr_i) && bank)
                rdata_o <= bank_hi_reg[boff[8:0]];
            else if (rd_i)
                rdata_o <= mem_reg[addr_i];
            // inhibited bits return the raw bit, undefined by contract
            if (bit_test_instr_i && fidx != 4'h8)
                bit_test_o <= flg_reg[fidx[2:0]][bit_sel_i];
            else if (bit_test_instr_i)
                bit_test_o <= 1'b0;
            for (i = 0; i < 32; i = i + 1)
                segment_o[i] <= mem_reg[`LCD_BASE + i][0];
        end
    end

endmodule
`default_nettype wire

//--- shared/ram_map_regs.vh
`ifndef RAM_MAP_REGS_VH
`define RAM_MAP_REGS_VH
// word addresses of the flag area
`define ICW0_ADDR   10'h000
`define ICW1_ADDR   10'h001
`define ICW2_ADDR   10'h002
`define ICW3_ADDR   10'h003
`define SFW0_ADDR   10'h020
`define SFW1_ADDR   10'h021
`define EIFW_ADDR   10'h022
`define SIFW_ADDR   10'h023
`define DCR_ADDR    10'h01b
// region bounds
`define MR_BASE     10'h040
`define MR_LAST     10'h04f
`define LCD_BASE    10'h05c
`define LCD_LAST    10'h07b
`define BANK_ADDR   10'h03f
`define DATA_BASE   10'h090
`define BANK_LAST   10'h25f
`define UPPER_LAST  10'h2ef
`define STACK_BASE  10'h3c0
`define STACK_LAST  10'h3ff
// bit positions in word 0 and system flag words
`define B_IE        0
`define B_RSP       1
`define B_LOW_SPEED_FLAG      0
`define B_WATCHDOG_ACTIVE_FLAG      1
`define B_CONVERSION_START_FLAG      2
`define B_DIRECT_TRANSFER_FLAG      3
`define B_CAPTURE_STATUS_FLAG      0
`define B_CAPTURE_ERROR_FLAG      1
`define B_CONVERTER_CURRENT_OFF_FLAG      2
`define B_RAM_ENABLED_FLAG      3
// reset values
`define FLAG_RST    4'h0
`define DCR_RST     4'h0
`endif

//--- dv/flag_area_props.sv
`timescale 1ns/100ps
`default_nettype none
module flag_area_props (
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic [9:0]  addr_i,
    input wire logic        wr_i,
    input wire logic        bit_set_instr_i,
    input wire logic        bit_clear_instr_i,
    input wire logic [1:0]  bit_sel_i,
    input wire logic        subactive_i,
    input wire logic        stop_cancel_input_i,
    input wire logic        subroutine_return_i,
    input wire logic        interrupt_return_i,
    input wire logic        restore_flags_o,
    input wire logic [3:0]  display_control_reg_o,
    input wire logic [31:0] flag_words_o,
    input wire logic        stack_ptr_clear_o
);
    // only software moves these bits, so hardware events cannot hide a slip
    localparam logic [31:0] FREE = 32'h8a41aaa9;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic       bs;
    logic       bc;
    logic       fw;
    logic [4:0] ix;
    // flat index of the addressed flag bit in flag_words_o
    assign bs = bit_set_instr_i;
    assign bc = bit_clear_instr_i;
    assign fw = addr_i[9:2] == 8'h00 || addr_i[9:2] == 8'h08;
    assign ix = {addr_i[5], addr_i[1:0], bit_sel_i};
    free_set_a: assert property (bs && fw && FREE[ix] |=> flag_words_o[$past(ix)])
        else $error("free flag not set");
    free_clr_a: assert property (bc && fw && FREE[ix] |=> !flag_words_o[$past(ix)])
        else $error("free flag not cleared");
    one_bit_a: assert property ((bs || bc) && fw |=> ((flag_words_o ^ $past(flag_words_o))
        & FREE & ~(32'h1 << $past(ix))) == 32'h0) else $error("other bits moved");
    write_keep_a: assert property (wr_i && !bs && !bc |=>
        (flag_words_o & FREE) == ($past(flag_words_o) & FREE)) else $error("write hit flags");
    unused_keep_a: assert property ((bs || bc) && addr_i == 10'h023 && !bit_sel_i[1]
        |=> $stable(flag_words_o[29:28])) else $error("unused bit changed");
    wdog_clr_a: assert property (bc && addr_i == 10'h020 && bit_sel_i == 2'd1 &&
        !stop_cancel_input_i |=> flag_words_o[17] == $past(flag_words_o[17]))
        else $error("watchdog flag cleared");
    wdog_stop_a: assert property (stop_cancel_input_i && !bs |=> !flag_words_o[17])
        else $error("stop cancel missed");
    direct_transfer_flag_active_a: assert property (!subactive_i [*2] |-> !flag_words_o[19])
        else $error("transfer flag set in active mode");
    sp_clear_a: assert property (bc && addr_i == 10'h000 && bit_sel_i == 2'd1
        |=> stack_ptr_clear_o) else $error("no stack clear pulse");
    dcr_set_a: assert property (bs && addr_i == 10'h01b
        |=> display_control_reg_o[$past(bit_sel_i)]) else $error("display bit not set");
    ret_flags_a: assert property (subroutine_return_i || interrupt_return_i
        |=> restore_flags_o == $past(interrupt_return_i)) else $error("flag restore wrong");
    cover property (bs && fw);
    cover property (interrupt_return_i);
    cover property (stop_cancel_input_i);
endmodule
bind ram_mapped_flag_register_area flag_area_props props_u (.mclk_i(mclk_i),
    .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .bit_set_instr_i(bit_set_instr_i),
    .bit_clear_instr_i(bit_clear_instr_i), .bit_sel_i(bit_sel_i),
    .subactive_i(subactive_i), .stop_cancel_input_i(stop_cancel_input_i),
    .subroutine_return_i(subroutine_return_i), .interrupt_return_i(interrupt_return_i),
    .restore_flags_o(restore_flags_o), .display_control_reg_o(display_control_reg_o),
    .flag_words_o(flag_words_o), .stack_ptr_clear_o(stack_ptr_clear_o));
`default_nettype wire

//--- dv/core_model.sv
`timescale 1ns/100ps
`default_nettype none
module core_model (
    input  wire logic       mclk_i,
    output var  logic [9:0] addr_o,
    output var  logic [3:0] data_o,
    output var  logic [4:0] req_o
);
    // req_o is read, write, bit set, bit clear, bit test
    initial {addr_o, data_o, req_o} = 19'h0;
    task op(input logic [4:0] k, input logic [9:0] a, input logic [3:0] d);
        // a conversion may be running, so its start flag is never cleared
        if (k == 5'b00010 && a == 10'h020 && d[1:0] == 2'd2) return;
        @(negedge mclk_i);
        addr_o = a;
        data_o = d;
        req_o = k;
        @(negedge mclk_i);
        req_o = 5'h0;
        // released lines show the inverse, not a stale copy
        addr_o = ~a;
        data_o = ~d;
    endtask
endmodule
`default_nettype wire

//--- dv/ram_mapped_flag_register_area_test.sv
`timescale 1ns/100ps
`default_nettype none
module ram_mapped_flag_register_area_test;
    localparam logic [4:0] RD = 5'h10, WR = 5'h08, SET = 5'h04, CLR = 5'h02;
    localparam logic [31:0] SETM = 32'h8a47aaa9;
    logic mclk_i = 0, rst_i = 1, sub = 0, st = 0, ca = 0;
    logic [18:0] ev = 19'h0;
    logic [13:0] pc = 14'h0, pc_o;
    logic [9:0] addr;
    logic [3:0] data, rdata_o, dcr_o;
    logic [4:0] req;
    logic [31:0] seg_o, fw_o, exp;
    logic bt_o, rf_o, sf_o, cf_o, rv_o;
    int n_mismatch = 0, tests_run = 0, cyc = 0;
    // events: irq requests, capture, ram, conversion, push, returns, stop
    core_model core_u (.mclk_i(mclk_i), .addr_o(addr), .data_o(data), .req_o(req));
    ram_mapped_flag_register_area dut_u (.mclk_i(mclk_i), .rst_i(rst_i),
        .addr_i(addr), .wdata_i(data), .rd_i(req[4]), .wr_i(req[3]),
        .bit_set_instr_i(req[2]), .bit_clear_instr_i(req[1]), .bit_test_instr_i(req[0]),
        .bit_sel_i(data[1:0]), .subactive_i(sub), .stop_cancel_input_i(ev[18]),
        .irq_req_i(ev[9:0]), .capture_status_set_i(ev[10]), .capture_error_set_i(ev[11]),
        .ram_enabled_set_i(ev[12]), .conversion_done_i(ev[13]), .call_push_i(ev[14]),
        .irq_push_i(ev[15]), .subroutine_return_i(ev[16]), .interrupt_return_i(ev[17]),
        .pc_i(pc), .status_flag_i(st), .carry_flag_i(ca), .rdata_o(rdata_o),
        .bit_test_o(bt_o), .pc_o(pc_o), .restore_flags_o(rf_o), .status_flag_o(sf_o),
        .carry_flag_o(cf_o), .restore_valid_o(rv_o), .segment_o(seg_o),
        .display_control_reg_o(dcr_o), .flag_words_o(fw_o), .stack_ptr_clear_o());
    initial forever #2.5 mclk_i = ~mclk_i;
    task chk(input string s, input logic [31:0] e, input logic [31:0] v);
        tests_run++;
        if (v !== e)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", s, e, v);
        end
    endtask
    task pulse(input logic [18:0] m);
        @(negedge mclk_i);
        ev = m;
        @(negedge mclk_i);
        ev = 19'h0;
    endtask
    task rdc(input logic [9:0] a, input logic [3:0] e);
        core_u.op(RD, a, 4'h0);
        chk("rdata", {28'h0, e}, {28'h0, rdata_o});
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // the whole sequence needs well under a thousand cycles
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            give_verdict;
        end
    end
    initial
    begin
        repeat (6) @(posedge mclk_i);
        @(negedge mclk_i) rst_i = 0;
        chk("reset", 32'h0, fw_o);
        pulse(19'h01fff);
        exp = 32'h45b05554;
        chk("requests", exp, fw_o);
        for (int i = 0; i < 32; i++)
        begin
            core_u.op(SET, {4'h0, i[4], 3'h0, i[3:2]}, {2'h0, i[1:0]});
            exp[i] = exp[i] | SETM[i];
            chk("set", exp, fw_o);
        end
        core_u.op(5'h01, 10'h000, 4'h0);
        chk("test", 32'h1, {31'h0, bt_o});
        for (int i = 0; i < 32; i++)
        begin
            core_u.op(CLR, {4'h0, i[4], 3'h0, i[3:2]}, {2'h0, i[1:0]});
            if (i != 17 && i != 18) exp[i] = 1'b0;
            chk("clear", exp, fw_o);
        end
        pulse(19'h42000);
        chk("stop", 32'h0, fw_o);
        sub = 1;
        core_u.op(SET, 10'h020, 4'h3);
        chk("direct_transfer_flag", 32'h80000, fw_o);
        sub = 0;
        repeat (2) @(negedge mclk_i);
        chk("direct_transfer_flag", 32'h0, fw_o);
        core_u.op(WR, 10'h000, 4'hf);
        rdc(10'h000, 4'h0);
        chk("write", 32'h0, fw_o);
        for (int b = 0; b < 4; b++) core_u.op(SET, 10'h01b, b[3:0]);
        chk("dcr", 32'hf, {28'h0, dcr_o});
        for (int i = 0; i < 16; i++) core_u.op(WR, 10'h040 + i[9:0], i[3:0]);
        for (int i = 0; i < 16; i++) rdc(10'h040 + i[9:0], i[3:0]);
        for (int i = 0; i < 32; i++) core_u.op(WR, 10'h05c + i[9:0], {3'h0, i % 3 == 0});
        chk("segments", 32'h49249249, seg_o);
        core_u.op(WR, 10'h03f, 4'h0);
        core_u.op(WR, 10'h090, 4'h5);
        core_u.op(WR, 10'h260, 4'h9);
        core_u.op(WR, 10'h03f, 4'h1);
        core_u.op(WR, 10'h090, 4'ha);
        rdc(10'h260, 4'h9);
        rdc(10'h090, 4'ha);
        core_u.op(WR, 10'h03f, 4'h0);
        rdc(10'h090, 4'h5);
        {pc, st, ca} = {14'h1234, 2'b10};
        pulse(19'h04000);
        {pc, st, ca} = {14'h2abc, 2'b01};
        pulse(19'h08000);
        {pc, st, ca} = {14'h0, 2'b10};
        pulse(19'h20000);
        chk("iret", {14'h2abc, 4'b0111}, {pc_o, sf_o, cf_o, rf_o, rv_o});
        pulse(19'h10000);
        chk("ret", {14'h1234, 2'b01}, {pc_o, rf_o, rv_o});
        core_u.op(WR, 10'h3f0, 4'h6);
        rdc(10'h3f0, 4'h6);
        give_verdict;
    end
endmodule
`default_nettype wire
